// ---- common/dts_pkg.sv ----
package dts_pkg;
	// Select byte layout, most significant bit first on the wire
	localparam int          SEL_TYPE_HI   = 7;
	localparam int          SEL_TYPE_LO   = 4;
	localparam int          SEL_AREA_BIT  = 3;
	localparam int          SEL_ONE_HI    = 2;
	localparam int          SEL_ONE_LO    = 1;
	localparam int          SEL_RW_BIT    = 0;
	localparam logic [1:0]  SEL_ONES      = 2'h3;
	// Device type identifier; value is arbitrary
	localparam logic [3:0]  DEV_TYPE_ID   = 4'h5;
	localparam int          ADDR_W        = 16;
	localparam logic [3:0]  BIT_LAST      = 4'h7;
	// Host register map (byte addresses)
	localparam logic [3:0]  HREG_CTRL     = 4'h0;
	localparam logic [3:0]  HREG_ADDR     = 4'h4;
	localparam logic [3:0]  HREG_STATUS   = 4'h8;
	localparam logic [3:0]  HREG_IRQ_STAT = 4'hC;
	localparam logic [3:0]  HREG_IRQ_CLR  = 4'hD;
	localparam logic [3:0]  HREG_IRQ_EN   = 4'hE;
	localparam logic [3:0]  HREG_RDATA    = 4'hF;
	// Control register fields
	localparam int          CTRL_GO       = 0;
	localparam int          CTRL_RW       = 1;
	localparam int          CTRL_AREA     = 2;
	// Interrupt bits: done, no acknowledge
	localparam int          IRQ_DONE      = 0;
	localparam int          IRQ_NACK      = 1;
	localparam int          IRQ_W         = 2;
	// Serial clock step less one, in system clocks; clock low for one step, high for two
	localparam logic [7:0]  HALF_PERIOD   = 8'h32;
	localparam logic [15:0] RST_VAL16     = 16'h0000;
endpackage

// ---- common/dts_if.sv ----
`timescale 1ns/10ps
interface dts_if;
	logic sclOut;         // Serial clock from master
	logic sdaHostOut;     // Host data driven low when enable low
	logic sdaHostOen;
	logic sdaDevOut;
	logic sdaDevOen;
	logic sdaLine;        // Resolved wired-AND level, set by bench
	modport dev  (input sclOut, input sdaLine, output sdaDevOut, output sdaDevOen);
	modport host (output sclOut, input sdaLine, output sdaHostOut, output sdaHostOen);
endinterface

// ---- rtl/dts_device.sv ----
`timescale 1ns/10ps
// Functional notes
// - Sample and shift bits on serial clock
// - Data line only pulled low or released
// - Activity pin shows write or command
// - Activity pin needs wired supply, open drain
// - Harvest output driven only enabled, field ok
// - Reader drops field fully for reset time
// - Ignore bus until supply above threshold
// - Threshold crossing resets, enters standby
// - Stop answering when supply drops below
// - Standby after Stop when no write
// - Select byte: type, area, ones, direction
// - Area bit chooses internal memory area
// - Select byte sent most significant first
// - Address sixteen bits, high and low byte
// - Receiver acknowledges in ninth bit time
// - Activity low for whole write or command
// - Master ends transfers with Stop
module dts_device
	import dts_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	dts_if.dev                         bus,
	input  wire logic                  supplyOk,
	input  wire logic                  fieldOk,
	input  wire logic                  harvestEnable,
	input  wire logic                  radioCommandIndicationMode,
	input  wire logic                  radioWriteActive,
	input  wire logic                  radioCommandActive,
	input  wire logic [7:0]            readByte,
	output logic                       radioActivityOut,
	output logic                       radioActivityOen,
	output logic                       harvestOen,
	output logic                       standby,
	output logic                       memoryAreaSelectBit,
	output logic [ADDR_W-1:0]          memAddr,
	output logic                       addrValid,
	output logic                       readMode,
	output logic                       readNextPulse
);
	typedef enum logic [2:0] {S_IDLE, S_SEL, S_ADRH, S_ADRL, S_DATA, S_RD} dts_dst_t;
	typedef struct packed {
		logic             sclD;
		logic             sdaD;
		logic             supD;
		dts_dst_t         st;
		logic [3:0]       bitCnt;
		logic [7:0]       shift;
		logic             ackPhase;
		logic             drvLow;
		logic             area;
		logic             rw;
		logic [ADDR_W-1:0] addr;
		logic             addrOk;
		logic             standby;
		logic             rdPulse;
	} dts_dev_state_t;
	dts_dev_state_t s_reg;
	dts_dev_state_t s_next;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic [7:0] rxByte;
	always_comb begin
		sclRise   = bus.sclOut & ~s_reg.sclD;
		sclFall   = ~bus.sclOut & s_reg.sclD;
		// Clock high in both samples, so a data change beside a clock edge is no start or stop
		startCond = bus.sclOut & s_reg.sclD & s_reg.sdaD & ~bus.sdaLine;
		stopCond  = bus.sclOut & s_reg.sclD & ~s_reg.sdaD & bus.sdaLine;
		rxByte    = {s_reg.shift[6:0], bus.sdaLine};
	end
	// Bus decoder; supply loss forces standby and ignores the bus
	always_comb begin
		s_next         = s_reg;
		s_next.sclD    = bus.sclOut;
		s_next.sdaD    = bus.sdaLine;
		s_next.supD    = supplyOk;
		s_next.rdPulse = 1'b0;
		if (!supplyOk) begin
			s_next.st      = S_IDLE;
			s_next.drvLow  = 1'b0;
			s_next.addrOk  = 1'b0;
			s_next.standby = 1'b1;
		end else if (!s_reg.supD) begin
			s_next.st       = S_IDLE;
			s_next.standby  = 1'b1;
			s_next.ackPhase = 1'b0;
			s_next.addr     = RST_VAL16;
		end else if (stopCond) begin
			s_next.st      = S_IDLE;
			s_next.drvLow  = 1'b0;
			s_next.standby = ~radioWriteActive;
		end else if (startCond) begin
			s_next.st       = S_SEL;
			s_next.bitCnt   = 4'h0;
			s_next.ackPhase = 1'b0;
			s_next.standby  = 1'b0;
		end else if (sclRise && s_reg.st != S_IDLE) begin
			if (s_reg.ackPhase) begin
				// Master acknowledge on read: low continues, high ends the read
				if (s_reg.st == S_RD && bus.sdaLine)
					s_next.st = S_IDLE;
			end else begin
				// Reads shift out from the top bit; writes shift the line in
				// A read takes zeros in; bits entering at the bottom reach the top bit only after the eighth rise, when no bit is driven from it
				s_next.shift  = (s_reg.st == S_RD) ? {s_reg.shift[6:0], 1'b0} : rxByte;
				s_next.bitCnt = s_reg.bitCnt + 4'h1;
			end
		end else if (sclFall && s_reg.st != S_IDLE) begin
			if (s_reg.ackPhase) begin
				s_next.ackPhase = 1'b0;
				s_next.drvLow   = 1'b0;
				s_next.bitCnt   = 4'h0;
				if (s_reg.st == S_RD) begin
					s_next.shift   = readByte;
					s_next.rdPulse = 1'b1;
					s_next.drvLow  = ~readByte[7];
					// Count restarts so that the eighth rise ends the byte
					s_next.bitCnt  = 4'h0;
				end
			end else if (s_reg.bitCnt == 4'h8) begin
				s_next.ackPhase = 1'b1;
				case (s_reg.st)
					S_SEL: begin
						// Wrong type or fixed ones: release and drop off the bus
						if (s_reg.shift[SEL_TYPE_HI:SEL_TYPE_LO] == DEV_TYPE_ID &&
							s_reg.shift[SEL_ONE_HI:SEL_ONE_LO] == SEL_ONES) begin
							s_next.area   = s_reg.shift[SEL_AREA_BIT];
							s_next.rw     = s_reg.shift[SEL_RW_BIT];
							s_next.drvLow = 1'b1;
							s_next.st     = s_reg.shift[SEL_RW_BIT] ? S_RD : S_ADRH;
						end else begin
							s_next.st       = S_IDLE;
							s_next.ackPhase = 1'b0;
						end
					end
					S_ADRH: begin
						s_next.addr[15:8] = s_reg.shift;
						s_next.drvLow     = 1'b1;
						s_next.st         = S_ADRL;
					end
					S_ADRL: begin
						s_next.addr[7:0] = s_reg.shift;
						s_next.addrOk    = 1'b1;
						s_next.drvLow    = 1'b1;
						s_next.st        = S_DATA;
					end
					S_DATA: begin
						s_next.drvLow = 1'b1;
						s_next.addr   = s_reg.addr + 16'h0001;
					end
					S_RD: begin
						s_next.drvLow = 1'b0; // Master answers here
						s_next.addr   = s_reg.addr + 16'h0001;
					end
					default: s_next.st = S_IDLE;
				endcase
			end else if (s_reg.st == S_RD) begin
				// Next bit goes out while the clock is low
				s_next.drvLow = ~s_reg.shift[7];
			end
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg         <= '0;
			s_reg.sclD    <= 1'b1;
			s_reg.sdaD    <= 1'b1;
			s_reg.st      <= S_IDLE;
			s_reg.standby <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end
	// Open-drain pins: enable low pulls the line low
	always_comb begin
		bus.sdaDevOut       = 1'b0;
		bus.sdaDevOen       = ~s_reg.drvLow;
		radioActivityOut    = 1'b0;
		radioActivityOen    = ~(supplyOk & (radioCommandIndicationMode ?
			radioCommandActive : radioWriteActive));
		harvestOen          = ~(harvestEnable & fieldOk);
		standby             = s_reg.standby;
		memoryAreaSelectBit = s_reg.area;
		memAddr             = s_reg.addr;
		addrValid           = s_reg.addrOk;
		readMode            = s_reg.rw;
		readNextPulse       = s_reg.rdPulse;
	end
endmodule

// ---- rtl/dts_host.sv ----
`timescale 1ns/10ps
module dts_host
	import dts_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	dts_if.host             bus,
	input  wire logic [3:0] regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic [15:0]     regRdata,
	output logic            irq
);
	typedef enum logic [2:0] {H_IDLE, H_START, H_BYTE, H_ACK, H_STOP} dts_hst_t;
	typedef struct packed {
		dts_hst_t   st;
		logic [7:0] div;
		logic [1:0] ph;
		logic [3:0] bitCnt;
		logic [1:0] byteIdx;
		logic [7:0] shift;
		logic       scl;
		logic       sdaLow;
		logic       rw;
		logic       rdPhase;
		logic       area;
		logic [15:0] addr;
		logic [7:0] rdata;
		logic       busy;
		logic       nack;
		logic [IRQ_W-1:0] irqStat;
		logic [IRQ_W-1:0] irqEn;
		logic [15:0] rd;
	} dts_host_state_t;
	dts_host_state_t s_reg;
	dts_host_state_t s_next;
	logic tick;
	logic [IRQ_W-1:0] evt;
	always_comb begin
		s_next   = s_reg;
		evt      = '0;
		tick     = (s_reg.div == HALF_PERIOD);
		s_next.div = tick ? 8'h00 : s_reg.div + 8'h01;
		if (regWr) begin
			case (regAddr)
				HREG_CTRL: if (regWdata[CTRL_GO] && !s_reg.busy) begin
					s_next.busy  = 1'b1;
					s_next.rw    = regWdata[CTRL_RW];
					s_next.area  = regWdata[CTRL_AREA];
					s_next.st    = H_START;
					s_next.ph    = 2'h0;
					s_next.nack  = 1'b0;
					s_next.rdPhase = 1'b0;
				end
				HREG_ADDR:    s_next.addr  = regWdata;
				HREG_IRQ_EN:  s_next.irqEn = regWdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		// Byte sequence: select, address high, address low, then on reads a repeated start, select and read byte
		if (tick) begin
			case (s_reg.st)
				H_START: begin
					s_next.ph = s_reg.ph + 2'h1;
					if (!s_reg.rdPhase || s_reg.ph == 2'h2) begin
						s_next.sdaLow  = 1'b1;
						s_next.st      = H_BYTE;
						s_next.ph      = 2'h0;
						s_next.bitCnt  = 4'h0;
						s_next.byteIdx = s_reg.rdPhase ? 2'h2 : 2'h0;
						s_next.shift   = {DEV_TYPE_ID, s_reg.area, SEL_ONES, s_reg.rdPhase};
					end else if (s_reg.ph == 2'h0) begin
						// Restart: release data with the clock low, then raise the clock
						s_next.scl    = 1'b0;
						s_next.sdaLow = 1'b0;
					end else begin
						s_next.scl = 1'b1;
					end
				end
				H_BYTE: begin
					s_next.ph = s_reg.ph + 2'h1;
					if (s_reg.ph == 2'h0) begin
						// Data moves only while the clock is low
						s_next.scl    = 1'b0;
						s_next.sdaLow = (s_reg.byteIdx == 2'h3) ? 1'b0 : ~s_reg.shift[7];
					end else if (s_reg.ph == 2'h1) begin
						s_next.scl    = 1'b1;
					end else begin
						s_next.ph     = 2'h0;
						s_next.shift  = {s_reg.shift[6:0], bus.sdaLine};
						s_next.bitCnt = s_reg.bitCnt + 4'h1;
						if (s_reg.bitCnt == BIT_LAST)
							s_next.st = H_ACK;
					end
				end
				H_ACK: begin
					s_next.ph = s_reg.ph + 2'h1;
					if (s_reg.ph == 2'h0) begin
						s_next.scl    = 1'b0;
						s_next.sdaLow = 1'b0;
					end else if (s_reg.ph == 2'h1) begin
						s_next.scl    = 1'b1; // Read ends with a not-acknowledge
					end else begin
						s_next.ph     = 2'h0;
						s_next.bitCnt = 4'h0;
						if (s_reg.byteIdx != 2'h3 && bus.sdaLine) begin
							s_next.nack = 1'b1;
							s_next.st   = H_STOP;
						end else if (s_reg.byteIdx == 2'h3 || (s_reg.byteIdx == 2'h2 && !s_reg.rw)) begin
							if (s_reg.byteIdx == 2'h3)
								s_next.rdata = s_reg.shift;
							s_next.st = H_STOP;
						end else if (s_reg.byteIdx == 2'h2 && !s_reg.rdPhase) begin
							s_next.st      = H_START; // Repeated start for the read
							s_next.rdPhase = 1'b1;
						end else if (s_reg.byteIdx == 2'h2) begin
							s_next.byteIdx = 2'h3;
							s_next.st      = H_BYTE;
						end else begin
							s_next.byteIdx = s_reg.byteIdx + 2'h1;
							s_next.shift   = (s_reg.byteIdx == 2'h0) ? s_reg.addr[15:8] : s_reg.addr[7:0];
							s_next.st      = H_BYTE;
						end
					end
				end
				H_STOP: begin
					s_next.ph = s_reg.ph + 2'h1;
					if (s_reg.ph == 2'h0) begin
						s_next.scl = 1'b0;
						s_next.sdaLow = 1'b1;
					end else if (s_reg.ph == 2'h1) begin
						s_next.scl = 1'b1;
					end else begin
						s_next.sdaLow = 1'b0;
						s_next.st     = H_IDLE;
						s_next.busy   = 1'b0;
						s_next.ph     = 2'h0;
						evt[IRQ_DONE] = 1'b1;
						evt[IRQ_NACK] = s_reg.nack;
					end
				end
				default: ;
			endcase
		end
		// Set wins over clear
		s_next.irqStat = (s_reg.irqStat & ~((regWr && regAddr == HREG_IRQ_CLR) ?
			regWdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | evt;
		s_next.rd = 16'h0000;
		if (regRd) begin
			case (regAddr)
				HREG_ADDR:     s_next.rd = s_reg.addr;
				HREG_STATUS:   s_next.rd = {13'h0000, s_reg.nack, s_reg.area, s_reg.busy};
				HREG_IRQ_STAT: s_next.rd = {14'h0000, s_reg.irqStat};
				HREG_IRQ_EN:   s_next.rd = {14'h0000, s_reg.irqEn};
				HREG_RDATA:    s_next.rd = {8'h00, s_reg.rdata};
				default:       s_next.rd = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_reg     <= '0;
			s_reg.st  <= H_IDLE;
			s_reg.scl <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end
	always_comb begin
		bus.sclOut     = s_reg.scl;
		bus.sdaHostOut = 1'b0;
		bus.sdaHostOen = ~s_reg.sdaLow;
		regRdata       = s_reg.rd;
		irq            = |(s_reg.irqStat & s_reg.irqEn);
	end
endmodule

// ---- dv/dts_assertions.sv ----
`timescale 1ns/10ps
module dts_assertions (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sclOut,
	input wire logic sdaHostOut,
	input wire logic sdaHostOen,
	input wire logic sdaDevOut,
	input wire logic sdaDevOen,
	input wire logic sdaLine
);
	import dts_pkg::*;
	logic [7:0] holdReg;
	logic       frameReg;
	logic       sclQReg;
	logic       lineQReg;
	logic       startSeen;
	logic       stopSeen;

	// Start and stop are data edges while the clock stays high
	assign startSeen = sclOut && sclQReg && !sdaLine && lineQReg;
	assign stopSeen  = sclOut && sclQReg && sdaLine && !lineQReg;

	// Clock level age, saturating so idle time never wraps
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			holdReg  <= 8'h00;
			frameReg <= 1'b0;
			sclQReg  <= 1'b1;
			lineQReg <= 1'b1;
		end else begin
			sclQReg  <= sclOut;
			lineQReg <= sdaLine;
			holdReg  <= (sclOut != sclQReg) ? 8'h00 : ((holdReg == 8'hFF) ? holdReg : holdReg + 8'h01);
			frameReg <= startSeen ? 1'b1 : (stopSeen ? 1'b0 : frameReg);
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	property p_devLowOnly;
		sdaDevOut == 1'b0;
	endproperty
	a_devLowOnly: assert property (p_devLowOnly) else $error("device data driver not low");
	property p_hostLowOnly;
		sdaHostOut == 1'b0;
	endproperty
	a_hostLowOnly: assert property (p_hostLowOnly) else $error("host data driver not low");
	property p_devHoldSclHigh;
		sclOut && sclQReg |-> $stable(sdaDevOen);
	endproperty
	a_devHoldSclHigh: assert property (p_devHoldSclHigh) else $error("device data moved with clock high");
	property p_devPullSclLow;
		$fell(sdaDevOen) |-> !sclOut;
	endproperty
	a_devPullSclLow: assert property (p_devPullSclLow) else $error("device pulled data with clock high");
	property p_sclHalfPeriod;
		(sclOut != sclQReg) |-> holdReg >= HALF_PERIOD - 8'h01;
	endproperty
	a_sclHalfPeriod: assert property (p_sclHalfPeriod) else $error("serial clock phase too short");
	property p_resetIdle;
		$rose(rst_n) |-> sclOut && sdaHostOen && sdaDevOen;
	endproperty
	a_resetIdle: assert property (p_resetIdle) else $error("bus not idle after reset");
	property p_stopRelease;
		stopSeen |-> sdaDevOen [*8];
	endproperty
	a_stopRelease: assert property (p_stopRelease) else $error("device drove data after stop");
	property p_devInFrame;
		!sdaDevOen |-> frameReg;
	endproperty
	a_devInFrame: assert property (p_devInFrame) else $error("device drove data outside a frame");
	property p_sclIdleHigh;
		!frameReg |-> sclOut;
	endproperty
	a_sclIdleHigh: assert property (p_sclIdleHigh) else $error("clock low outside a frame");

	// Main traffic shapes reached
	c_start: cover property (startSeen);
	c_devAck: cover property ($fell(sdaDevOen));
	c_stop: cover property (stopSeen);
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	import dts_pkg::*;
	logic        clk_sys, rst_n, supplyOk, fieldOk, harvestEnable, cmdMode, wrAct, cmdAct, regWr, regRd;
	logic        actOen, harvestOen, standby, areaBit, addrValid, readPulse, irq, readMode;
	logic        sclQ = 1'b1, sdaQ = 1'b1;
	logic [3:0]  regAddr;
	logic [7:0]  readByte, selSeen;
	logic [15:0] regWdata, regRdata, memAddr, rd;
	int          failures = 0, totalChecks = 0, cycles = 0, bitCnt = 9, pulses = 0;
	// Pin rows: supply, field, harvest, command mode, write, command, harvest enable, activity enable
	logic [7:0]  rows [8] = '{8'hE8, 8'hA7, 8'hD6, 8'hF9, 8'h75, 8'h69, 8'h83, 8'hFC};

	dts_if bus ();
	// Pull-up makes the data line a wired AND
	assign bus.sdaLine = bus.sdaHostOen & bus.sdaDevOen;

	dts_host i_dts_host (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .regAddr(regAddr), .regWdata(regWdata),
		.regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
	dts_device i_dts_device (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus), .supplyOk(supplyOk), .fieldOk(fieldOk),
		.harvestEnable(harvestEnable), .radioCommandIndicationMode(cmdMode), .radioWriteActive(wrAct),
		.radioCommandActive(cmdAct), .readByte(readByte), .radioActivityOut(), .radioActivityOen(actOen),
		.harvestOen(harvestOen), .standby(standby), .memoryAreaSelectBit(areaBit), .memAddr(memAddr),
		.addrValid(addrValid), .readMode(readMode), .readNextPulse(readPulse));
	dts_assertions i_dts_assertions (.clk_sys(clk_sys), .rst_n(rst_n), .sclOut(bus.sclOut),
		.sdaHostOut(bus.sdaHostOut), .sdaHostOen(bus.sdaHostOen), .sdaDevOut(bus.sdaDevOut),
		.sdaDevOen(bus.sdaDevOen), .sdaLine(bus.sdaLine));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Select byte as seen on the wire, restarted at each start; clocked to avoid pin races
	always @(posedge clk_sys) begin
		sclQ <= bus.sclOut;
		sdaQ <= bus.sdaLine;
		if (bus.sclOut && sclQ && sdaQ && !bus.sdaLine) begin
			bitCnt = 0;
		end else if (bus.sclOut && !sclQ && bitCnt < 8) begin
			selSeen = {selSeen[6:0], bus.sdaLine};
			bitCnt++;
		end
	end

	// Hang guard and read strobe count
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (readPulse) pulses <= pulses + 1;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic regW(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic regR(input logic [3:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 rd = regRdata;
	endtask

	// Launch one transfer, poll interrupt status under a bound
	task automatic xfer(input logic [15:0] ctrl);
		int n;
		regW(HREG_IRQ_CLR, 16'h0003);
		regW(HREG_CTRL, ctrl);
		rd = 16'h0000;
		for (n = 0; n < 4000 && rd === 16'h0000; n++) regR(HREG_IRQ_STAT);
	endtask

	task automatic tally_and_finish();
		if (failures == 0 && totalChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		{rst_n, fieldOk, harvestEnable, cmdMode, wrAct, cmdAct, regWr, regRd} = 8'h00;
		supplyOk = 1'b1;
		regAddr = 4'h0;
		regWdata = 16'h0000;
		readByte = 8'hC3;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1 check({standby, addrValid, bus.sclOut, bus.sdaLine}, 4'hB);
		check(memAddr, 16'h0000);
		regR(HREG_STATUS);
		check(rd, 16'h0000);
		regR(4'h3);
		check(rd, 16'h0000);
		// Pin table rows
		foreach (rows[i]) begin
			@(posedge clk_sys);
			{supplyOk, fieldOk, harvestEnable, cmdMode, wrAct, cmdAct} <= rows[i][7:2];
			@(posedge clk_sys);
			#1 check({harvestOen, actOen}, rows[i][1:0]);
		end
		// No radio write running, so a stop may enter standby
		@(posedge clk_sys);
		{wrAct, cmdAct} <= 2'h0;
		// Address write with the area bit set
		regW(HREG_ADDR, 16'hA55A);
		xfer(16'h0005);
		check(rd[1:0], 2'h1);
		check(selSeen, {DEV_TYPE_ID, 1'b1, SEL_ONES, 1'b0});
		check(memAddr, 16'hA55A);
		check({areaBit, addrValid}, 2'h3);
		check(readMode, 1'b0);
		repeat (400) if (!standby) @(posedge clk_sys);
		check(standby, 1'b1);
		// Interrupt masked, then enabled, then cleared
		check(irq, 1'b0);
		regW(HREG_IRQ_EN, 16'h0003);
		#1 check(irq, 1'b1);
		regW(HREG_IRQ_CLR, 16'h0001);
		#1 check(irq, 1'b0);
		// Read direction after a repeated start
		xfer(16'h0003);
		check(selSeen, {DEV_TYPE_ID, 1'b0, SEL_ONES, 1'b1});
		check(areaBit, 1'b0);
		check(readMode, 1'b1);
		regR(HREG_RDATA);
		check(rd[7:0], 8'hC3);
		check(16'(pulses), 16'h0001);
		// No supply: the select byte goes unanswered
		supplyOk <= 1'b0;
		xfer(16'h0001);
		check(rd[1], 1'b1);
		supplyOk <= 1'b1;
		// Reset in mid transfer
		regW(HREG_CTRL, 16'h0001);
		repeat (700) @(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1 check({standby, addrValid, bus.sclOut, bus.sdaLine}, 4'hB);
		check(memAddr, 16'h0000);
		tally_and_finish();
	end
endmodule
